//--- common/fcsr_defines.vh
// Constants for the flash command sequencer: commands, status bits,
// state codes, block geometry and partition layout.
// Assumes a 16-bit command bus and a 22-bit word address.
// Function
// (R1) Busy partition array read returns invalid data; the last started op's partition is blanked, also after an erase resumes
// (R2) Program suspended: erase setup then confirm ignored
// (R3) Clear status only while no operation runs
// (R4) Buffered data accepted only while status bit0 low
// (R5) Each partition keeps its own output selection
// (R6) Chip next state ignores partition output selection
// (R7) Lock and configuration confirms act, then ready
// (R8) First-cycle block address latched for later compares
// (R9) Erase one block: 32 or 128 KByte
// (R10) Parameter blocks top or bottom per variant
// (R11) Host polls status before touching busy partitions
`ifndef FCSR_DEFINES_VH
`define FCSR_DEFINES_VH

`define FCSR_ADDR_W 22
`define FCSR_DATA_W 16
`define FCSR_NPART 8
`define FCSR_PART_LSB 19
`define FCSR_MAIN_LSB 16
`define FCSR_PARAM_LSB 14
`define FCSR_PARAM_REGION 6'h3F
`define FCSR_BOTTOM_REGION 6'h00
`define FCSR_MAIN_KBYTE 128
`define FCSR_PARAM_KBYTE 32

`define FCSR_CMD_READ_ARRAY 8'hFF
`define FCSR_CMD_PGM_A 8'h40
`define FCSR_CMD_PGM_B 8'h10
`define FCSR_CMD_ERASE 8'h20
`define FCSR_CMD_BUFPGM 8'h30
`define FCSR_CMD_CONFIRM 8'hD0
`define FCSR_CMD_SUSPEND 8'hB0
`define FCSR_CMD_READ_STATUS 8'h70
`define FCSR_CMD_CLEAR_STATUS 8'h50
`define FCSR_CMD_READ_ID 8'h90
`define FCSR_CMD_READ_QUERY 8'h98
`define FCSR_CMD_LOCK_SETUP 8'h60
`define FCSR_CMD_OTP_SETUP 8'hC0
`define FCSR_CMD_LOCK 8'h01
`define FCSR_CMD_LOCKDOWN 8'h2F
`define FCSR_CMD_CFG 8'h03
`define FCSR_BUFPGM_EXIT 16'hFFFF
`define FCSR_INVALID_DATA 16'hFFFF

`define FCSR_SR_READY 7
`define FCSR_SR_ERS_SUSP 6
`define FCSR_SR_ERS_ERR 5
`define FCSR_SR_PGM_ERR 4
`define FCSR_SR_PGM_SUSP 2
`define FCSR_SR_LOCK_ERR 1
`define FCSR_SR_BUF_BUSY 0

`define FCSR_MUX_ARRAY 2'h0
`define FCSR_MUX_ID 2'h1
`define FCSR_MUX_STATUS 2'h2

`define FCSR_OP_PGM 3'h0
`define FCSR_OP_ERASE 3'h1
`define FCSR_OP_OTP 3'h2
`define FCSR_OP_BUFPGM 3'h3
`define FCSR_OP_LOCK 3'h4
`define FCSR_OP_UNLOCK 3'h5
`define FCSR_OP_LOCKDOWN 3'h6
`define FCSR_OP_CFG 3'h7

`define FCSR_S_READY 11'h001
`define FCSR_S_PGM_SETUP 11'h002
`define FCSR_S_PGM_BUSY 11'h004
`define FCSR_S_ERS_SETUP 11'h008
`define FCSR_S_ERS_BUSY 11'h010
`define FCSR_S_ERS_SUSP 11'h020
`define FCSR_S_PGM_SUSP 11'h040
`define FCSR_S_PSUSP_ERS 11'h080
`define FCSR_S_LOCK_SETUP 11'h100
`define FCSR_S_OTP_SETUP 11'h200
`define FCSR_S_BUF_BUSY 11'h400

`endif

//--- src/fcsr_block_decode.v
// Block decoder: maps a word address to its erase block base and size.
// Assumes the variant strap is steady while the part is in use.
`default_nettype none
`include "fcsr_defines.vh"
module fcsr_block_decode
(
   input wire [`FCSR_ADDR_W-1:0] i_addr, // Word address
   input wire i_top_param, // High: parameter blocks at top
   output wire [`FCSR_ADDR_W-1:0] o_block_base, // First word of block
   output wire o_is_param // Address lies in a parameter block
);
   wire [5:0] main_idx;
   assign main_idx = i_addr[`FCSR_ADDR_W-1:`FCSR_MAIN_LSB];
   // Parameter region is one main-block slot split in four [R10]
   assign o_is_param = i_top_param ? (main_idx == `FCSR_PARAM_REGION) :
                       (main_idx == `FCSR_BOTTOM_REGION);
   // Block granularity: 32 KByte or 128 KByte [R9]
   assign o_block_base = o_is_param ?
      {i_addr[`FCSR_ADDR_W-1:`FCSR_PARAM_LSB], {`FCSR_PARAM_LSB{1'b0}}} :
      {main_idx, {`FCSR_MAIN_LSB{1'b0}}};
endmodule
`default_nettype wire

//--- src/fcsr_sequencer.v
// Flash command sequencer: decodes host command cycles, tracks the chip
// state, per-partition output selection and the status register.
// Assumes an array engine that runs each started operation and pulses done.
`default_nettype none
`include "fcsr_defines.vh"
module fcsr_sequencer
(
   input wire i_sys_clk, // System clock
   input wire i_rst, // Synchronous reset, active high
   input wire i_top_param, // Variant strap, high for top parameter
   input wire i_wr, // Host write cycle strobe
   input wire [`FCSR_ADDR_W-1:0] i_wr_addr, // Write address
   input wire [`FCSR_DATA_W-1:0] i_wr_data, // Write data
   input wire i_rd, // Host read strobe
   input wire [`FCSR_ADDR_W-1:0] i_rd_addr, // Read address
   input wire [`FCSR_DATA_W-1:0] i_array_data, // Array word at read address
   input wire [`FCSR_DATA_W-1:0] i_id_data, // Identifier or query word
   input wire i_op_done, // Engine finished operation, pulse
   input wire i_op_fail, // Engine failure, valid with done
   input wire i_buf_busy, // Buffered programming buffer full
   output reg [`FCSR_DATA_W-1:0] o_rd_data, // Read data
   output reg o_rd_valid, // Read data valid, pulse
   output reg o_op_start, // Start engine operation, pulse
   output reg [2:0] o_op_kind, // Operation code
   output reg [`FCSR_ADDR_W-1:0] o_op_addr, // Operation address
   output reg [`FCSR_DATA_W-1:0] o_op_data, // Program data
   output reg o_buf_wr, // Buffered data word, pulse
   output reg o_suspend, // Suspend running operation, held until done
   output reg o_resume, // Resume suspended operation, pulse
   output wire [7:0] o_status // Status register
);
   reg [10:0] state_q, state_d;
   reg in_ers_susp_q, in_ers_susp_d;
   reg [`FCSR_ADDR_W-1:0] first_cycle_block_address_q, first_cycle_block_address_d, addr_d;
   reg [1:0] pgm_err_q, err_q, mux_cmd_d;
   reg [2:0] busy_part_q, kind_d;
   reg start_d, buf_wr_d, suspend_d, resume_d, clear_d, mux_upd_d;
   wire [7:0] cmd;
   wire [2:0] wr_part, rd_part;
   wire [`FCSR_ADDR_W-1:0] wr_block;
   wire running;
   wire [1:0] rd_mux;
   wire [2*`FCSR_NPART-1:0] mux_flat;
   assign cmd = i_wr_data[7:0];
   assign wr_part = i_wr_addr[`FCSR_ADDR_W-1:`FCSR_PART_LSB];
   assign rd_part = i_rd_addr[`FCSR_ADDR_W-1:`FCSR_PART_LSB];
   assign running = (state_q == `FCSR_S_PGM_BUSY) || (state_q == `FCSR_S_ERS_BUSY) ||
                    (state_q == `FCSR_S_BUF_BUSY);
   fcsr_block_decode u_dec
   (
      .i_addr(i_wr_addr),
      .i_top_param(i_top_param),
      .o_block_base(wr_block),
      .o_is_param()
   );
   assign o_status = {~running, state_q == `FCSR_S_ERS_SUSP, err_q[1], err_q[0],
                      1'b0, state_q == `FCSR_S_PGM_SUSP, pgm_err_q[1],
                      i_buf_busy && (state_q == `FCSR_S_BUF_BUSY)};
   // Chip next state never reads the partition output selection [R6]
   always @*
   begin
      state_d = state_q;
      in_ers_susp_d = in_ers_susp_q;
      first_cycle_block_address_d = first_cycle_block_address_q;
      start_d = 1'b0;
      kind_d = o_op_kind;
      addr_d = o_op_addr;
      buf_wr_d = 1'b0;
      suspend_d = 1'b0;
      resume_d = 1'b0;
      clear_d = 1'b0;
      mux_upd_d = 1'b0;
      mux_cmd_d = `FCSR_MUX_STATUS;
      if (i_wr)
      begin
         case (state_q)
            `FCSR_S_READY, `FCSR_S_ERS_SUSP:
            begin
               mux_upd_d = 1'b1;
               case (cmd)
                  `FCSR_CMD_READ_ARRAY: mux_cmd_d = `FCSR_MUX_ARRAY;
                  `FCSR_CMD_READ_ID, `FCSR_CMD_READ_QUERY: mux_cmd_d = `FCSR_MUX_ID;
                  `FCSR_CMD_PGM_A, `FCSR_CMD_PGM_B:
                  begin
                     in_ers_susp_d = (state_q == `FCSR_S_ERS_SUSP);
                     state_d = `FCSR_S_PGM_SETUP;
                  end
                  `FCSR_CMD_LOCK_SETUP:
                  begin
                     in_ers_susp_d = (state_q == `FCSR_S_ERS_SUSP);
                     state_d = `FCSR_S_LOCK_SETUP;
                  end
                  `FCSR_CMD_CONFIRM:
                     if (state_q == `FCSR_S_ERS_SUSP)
                     begin
                        resume_d = 1'b1;
                        state_d = `FCSR_S_ERS_BUSY;
                     end
                  `FCSR_CMD_CLEAR_STATUS: clear_d = 1'b1; // [R3]
                  default:
                     if (state_q == `FCSR_S_READY)
                     begin
                        // Latch block for confirm and data compares [R8]
                        first_cycle_block_address_d = wr_block;
                        if (cmd == `FCSR_CMD_ERASE)
                           state_d = `FCSR_S_ERS_SETUP;
                        else if (cmd == `FCSR_CMD_BUFPGM)
                           state_d = `FCSR_S_BUF_BUSY;
                        else if (cmd == `FCSR_CMD_OTP_SETUP)
                           state_d = `FCSR_S_OTP_SETUP;
                        else if (cmd != `FCSR_CMD_READ_STATUS)
                           mux_upd_d = 1'b0;
                        if (cmd == `FCSR_CMD_BUFPGM)
                        begin
                           start_d = 1'b1;
                           kind_d = `FCSR_OP_BUFPGM;
                           addr_d = wr_block;
                        end
                     end
                     else if (cmd != `FCSR_CMD_READ_STATUS)
                        mux_upd_d = 1'b0;
               endcase
            end
            `FCSR_S_PGM_SETUP, `FCSR_S_OTP_SETUP:
            begin
               start_d = 1'b1;
               kind_d = (state_q == `FCSR_S_OTP_SETUP) ? `FCSR_OP_OTP : `FCSR_OP_PGM;
               addr_d = i_wr_addr;
               state_d = `FCSR_S_PGM_BUSY;
            end
            `FCSR_S_ERS_SETUP:
            begin
               if (cmd == `FCSR_CMD_CONFIRM)
               begin
                  // One whole block erased, from the latched base [R9] [R8]
                  start_d = 1'b1;
                  kind_d = `FCSR_OP_ERASE;
                  addr_d = first_cycle_block_address_q;
                  state_d = `FCSR_S_ERS_BUSY;
               end
               else
                  state_d = `FCSR_S_READY;
            end
            `FCSR_S_LOCK_SETUP:
            begin
               addr_d = (cmd == `FCSR_CMD_CFG) ? i_wr_addr : wr_block;
               start_d = 1'b1;
               case (cmd)
                  `FCSR_CMD_LOCK: kind_d = `FCSR_OP_LOCK;
                  `FCSR_CMD_CONFIRM: kind_d = `FCSR_OP_UNLOCK;
                  `FCSR_CMD_LOCKDOWN: kind_d = `FCSR_OP_LOCKDOWN;
                  `FCSR_CMD_CFG: kind_d = `FCSR_OP_CFG;
                  default: start_d = 1'b0;
               endcase
               // Act, then back to ready or the suspend it came from [R7]
               state_d = in_ers_susp_q ? `FCSR_S_ERS_SUSP : `FCSR_S_READY;
            end
            `FCSR_S_PGM_BUSY, `FCSR_S_ERS_BUSY:
            begin
               if (cmd == `FCSR_CMD_SUSPEND && !(in_ers_susp_q && state_q == `FCSR_S_PGM_BUSY))
                  suspend_d = 1'b1;
               mux_upd_d = (cmd == `FCSR_CMD_READ_STATUS) || (cmd == `FCSR_CMD_READ_ARRAY) ||
                           (cmd == `FCSR_CMD_READ_ID) || (cmd == `FCSR_CMD_READ_QUERY);
               mux_cmd_d = (cmd == `FCSR_CMD_READ_ARRAY) ? `FCSR_MUX_ARRAY :
                           (cmd == `FCSR_CMD_READ_STATUS) ? `FCSR_MUX_STATUS : `FCSR_MUX_ID;
            end
            `FCSR_S_PGM_SUSP:
            begin
               if (cmd == `FCSR_CMD_CONFIRM)
               begin
                  resume_d = 1'b1;
                  state_d = `FCSR_S_PGM_BUSY;
               end
               else if (cmd == `FCSR_CMD_ERASE)
                  state_d = `FCSR_S_PSUSP_ERS;
               mux_upd_d = 1'b1;
               if (cmd == `FCSR_CMD_READ_ARRAY)
                  mux_cmd_d = `FCSR_MUX_ARRAY;
               else if (cmd == `FCSR_CMD_READ_ID || cmd == `FCSR_CMD_READ_QUERY)
                  mux_cmd_d = `FCSR_MUX_ID;
               else if (cmd == `FCSR_CMD_CLEAR_STATUS)
                  clear_d = 1'b1;
            end
            `FCSR_S_PSUSP_ERS:
               // Ambiguous second cycle dropped, stay suspended [R2]
               state_d = `FCSR_S_PGM_SUSP;
            `FCSR_S_BUF_BUSY:
            begin
               if (i_wr_data == `FCSR_BUFPGM_EXIT && wr_block != first_cycle_block_address_q)
                  state_d = `FCSR_S_ERS_BUSY;
               else if (!i_buf_busy && wr_block == first_cycle_block_address_q)
                  buf_wr_d = 1'b1; // Dropped while buffer is full [R4]
            end
            default: state_d = `FCSR_S_READY;
         endcase
      end
      // Done under a raised suspend is its acknowledge, not the finish
      if (i_op_done && o_suspend)
         state_d = (state_q == `FCSR_S_PGM_BUSY) ? `FCSR_S_PGM_SUSP : `FCSR_S_ERS_SUSP;
      else if (i_op_done && running)
      begin
         state_d = in_ers_susp_q && state_q == `FCSR_S_PGM_BUSY ? `FCSR_S_ERS_SUSP :
                   `FCSR_S_READY;
         if (state_q == `FCSR_S_PGM_BUSY)
            in_ers_susp_d = 1'b0;
      end
   end
   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         state_q <= `FCSR_S_READY;
         in_ers_susp_q <= 1'b0;
         first_cycle_block_address_q <= {`FCSR_ADDR_W{1'b0}};
         o_op_start <= 1'b0;
         o_op_kind <= `FCSR_OP_PGM;
         o_op_addr <= {`FCSR_ADDR_W{1'b0}};
         o_op_data <= {`FCSR_DATA_W{1'b0}};
         o_buf_wr <= 1'b0;
         o_suspend <= 1'b0;
         o_resume <= 1'b0;
         err_q <= 2'h0;
         pgm_err_q <= 2'h0;
         busy_part_q <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         in_ers_susp_q <= in_ers_susp_d;
         first_cycle_block_address_q <= first_cycle_block_address_d;
         o_op_start <= start_d;
         o_op_kind <= kind_d;
         o_op_addr <= addr_d;
         if (start_d || buf_wr_d)
            o_op_data <= i_wr_data;
         o_buf_wr <= buf_wr_d;
         o_suspend <= suspend_d || (o_suspend && !i_op_done);
         o_resume <= resume_d;
         if (start_d)
            busy_part_q <= addr_d[`FCSR_ADDR_W-1:`FCSR_PART_LSB];
         // Failure sets win over a clear in the same cycle
         if (clear_d && !running) // [R3]
         begin
            err_q <= 2'h0;
            pgm_err_q <= 2'h0;
         end
         if (i_op_done && i_op_fail)
         begin
            if (o_op_kind == `FCSR_OP_ERASE)
               err_q[1] <= 1'b1;
            else if (o_op_kind >= `FCSR_OP_LOCK)
               pgm_err_q[1] <= 1'b1;
            else
               err_q[0] <= 1'b1;
         end
      end
   end
   // Per-partition output selection, updated by the addressed partition [R5]
   genvar gp;
   generate
      for (gp = 0; gp < `FCSR_NPART; gp = gp + 1)
      begin : g_part
         reg [1:0] mux_q;
         always @(posedge i_sys_clk)
         begin
            if (i_rst)
               mux_q <= `FCSR_MUX_ARRAY;
            else if (mux_upd_d && wr_part == gp)
               mux_q <= mux_cmd_d;
         end
         assign mux_flat[2*gp+1:2*gp] = mux_q;
      end
   endgenerate
   assign rd_mux = mux_flat[2*rd_part+:2];
   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_rd_data <= {`FCSR_DATA_W{1'b0}};
         o_rd_valid <= 1'b0;
      end
      else
      begin
         o_rd_valid <= i_rd;
         if (i_rd)
         begin
            if (rd_mux == `FCSR_MUX_STATUS)
               o_rd_data <= {8'h00, o_status};
            else if (rd_mux == `FCSR_MUX_ID)
               o_rd_data <= i_id_data;
            else if (running && rd_part == busy_part_q)
               o_rd_data <= `FCSR_INVALID_DATA; // [R1]
            else
               o_rd_data <= i_array_data;
         end
      end
   end
endmodule
`default_nettype wire

//--- sim/fcsr_seq_monitor.sv
// Concurrent checks on the command sequencer ports.
// Assumes one clock domain; bound onto fcsr_sequencer below.
`default_nettype none
module fcsr_seq_monitor
(
   input wire logic i_sys_clk, // Clock
   input wire logic i_rst, // Sync reset
   input wire logic i_wr, // Write strobe
   input wire logic [21:0] i_wr_addr, // Write address
   input wire logic [15:0] i_wr_data, // Write data
   input wire logic i_rd, // Read strobe
   input wire logic i_op_done, // Engine done
   input wire logic o_rd_valid, // Read valid
   input wire logic o_op_start, // Start pulse
   input wire logic [2:0] o_op_kind, // Operation code
   input wire logic [21:0] o_op_addr, // Operation address
   input wire logic o_buf_wr, // Buffered word taken
   input wire logic o_suspend, // Suspend level
   input wire logic o_resume, // Resume pulse
   input wire logic [7:0] o_status // Status
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // Ready and nothing parked, so a setup command starts fresh
   wire idle_st = o_status[7] && !o_status[6] && !o_status[2];
   wire [5:0] wr_region = i_wr_addr[21:16];
   sequence s_ers_pair;
      i_wr && i_wr_data[7:0] == 8'h20 ##1 i_wr && i_wr_data[7:0] == 8'hD0;
   endsequence
   sequence s_lock_pair;
      i_wr && i_wr_data[7:0] == 8'h60 ##1
      i_wr && i_wr_data[7:0] inside {8'h01, 8'hD0, 8'h2F, 8'h03};
   endsequence
   property p_erase_addr;
      !i_wr ##1 (idle_st && wr_region != 6'h3F && wr_region != 6'h00) ##0 s_ers_pair
      |=> o_op_start && o_op_kind == 3'h1 && o_op_addr == {$past(wr_region, 2), 16'h0000};
   endproperty
   property p_susp_ignore;
      !i_wr ##1 o_status[2] ##0 s_ers_pair |=> !o_op_start && !o_resume;
   endproperty
   property p_lock_ready;
      !i_wr ##1 idle_st ##0 s_lock_pair |=> o_op_start && o_op_kind[2] ##1 o_status[7];
   endproperty
   property p_rd_timing;
      o_rd_valid == $past(i_rd);
   endproperty
   property p_buf_drop;
      i_wr && o_status[0] |=> !o_buf_wr;
   endproperty
   property p_clr_busy;
      i_wr && i_wr_data[7:0] == 8'h50 && !o_status[7] && !i_op_done |=> $stable(o_status[5:4]);
   endproperty
   property p_clr_ready;
      !i_wr ##1 i_wr && i_wr_data[7:0] == 8'h50 && idle_st |=> o_status[5:4] == 2'h0 && !o_status[1];
   endproperty
   property p_susp_hold;
      o_suspend && !i_op_done |=> o_suspend;
   endproperty
   property p_start_pulse;
      o_op_start |=> !o_op_start;
   endproperty
   a_erase_addr: assert property (p_erase_addr) else $error("erase start wrong");
   a_susp_ignore: assert property (p_susp_ignore) else $error("ambiguous pair acted");
   a_lock_ready: assert property (p_lock_ready) else $error("lock confirm wrong");
   a_rd_timing: assert property (p_rd_timing) else $error("read valid timing");
   a_buf_drop: assert property (p_buf_drop) else $error("word taken while full");
   a_clr_busy: assert property (p_clr_busy) else $error("clear acted while busy");
   a_clr_ready: assert property (p_clr_ready) else $error("clear not done");
   a_susp_hold: assert property (p_susp_hold) else $error("suspend dropped early");
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");
endmodule
bind fcsr_sequencer fcsr_seq_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wr(i_wr),
   .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd(i_rd), .i_op_done(i_op_done),
   .o_rd_valid(o_rd_valid), .o_op_start(o_op_start), .o_op_kind(o_op_kind),
   .o_op_addr(o_op_addr), .o_buf_wr(o_buf_wr), .o_suspend(o_suspend), .o_resume(o_resume),
   .o_status(o_status));
`default_nettype wire

//--- sim/fcsr_engine_model.sv
// Array engine model: finishes operations, acknowledges suspends and
// holds the buffer full for two cycles after each buffered word.
// Assumes the sequencer's registered start, suspend and resume outputs.
`default_nettype none
module fcsr_engine_model #(parameter int DELAY = 20)
(
   input wire logic i_sys_clk, // Clock
   input wire logic i_rst, // Sync reset
   input wire logic i_start, // Operation start
   input wire logic [2:0] i_kind, // Operation code
   input wire logic i_suspend, // Suspend level
   input wire logic i_resume, // Resume pulse
   input wire logic i_buf_wr, // Buffered word
   input wire logic i_kick, // Finish buffered run
   input wire logic i_fail_req, // Fail the next done
   output logic o_done, // Done pulse
   output logic o_fail, // Failure with done
   output logic o_buf_busy // Buffer full
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   int bcnt;
   logic susp_q;
   assign o_fail = o_done & i_fail_req;
   assign o_buf_busy = bcnt != 0;
   always @(posedge i_sys_clk)
   begin
      o_done <= cnt == 1;
      if (cnt != 0) cnt <= cnt - 1;
      if (bcnt != 0) bcnt <= bcnt - 1;
      if (i_buf_wr) bcnt <= 2;
      // Lock and configuration kinds finish at once, no done
      if ((i_start && i_kind < 3'h3) || i_resume || i_kick) cnt <= DELAY;
      if (i_suspend && !susp_q) cnt <= 2;
      susp_q <= i_suspend;
      if (i_rst)
      begin
         cnt <= 0;
         bcnt <= 0;
         o_done <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- sim/tb_flash_command_state_rules.sv
// Self-checking bench for the flash command sequencer.
// Assumes the engine model and the bound port monitor.
`default_nettype none
module tb_flash_command_state_rules;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, top = 1'b0, wr = 1'b0, rd = 1'b0, kick = 1'b0, fail = 1'b0;
   logic [21:0] wa = 22'h000000, ra = 22'h000000, oa, a, b;
   logic [15:0] wd = 16'h0000, arr = 16'h0000, idd = 16'h0000, rdat, od, d;
   logic done, ofail, bbusy, rv, st, bw, sus, res;
   logic [2:0] kind;
   logic [7:0] stat;
   logic [15:0] lk [4] = '{16'h0001, 16'h00D0, 16'h002F, 16'h0003};
   int n_errors = 0, comparisons = 0, cyc = 0;
   always #5 clk = ~clk;
   fcsr_sequencer uut (.i_sys_clk(clk), .i_rst(rst), .i_top_param(top), .i_wr(wr),
      .i_wr_addr(wa), .i_wr_data(wd), .i_rd(rd), .i_rd_addr(ra), .i_array_data(arr),
      .i_id_data(idd), .i_op_done(done), .i_op_fail(ofail), .i_buf_busy(bbusy),
      .o_rd_data(rdat), .o_rd_valid(rv), .o_op_start(st), .o_op_kind(kind), .o_op_addr(oa),
      .o_op_data(od), .o_buf_wr(bw), .o_suspend(sus), .o_resume(res), .o_status(stat));
   fcsr_engine_model eng (.i_sys_clk(clk), .i_rst(rst), .i_start(st), .i_kind(kind),
      .i_suspend(sus), .i_resume(res), .i_buf_wr(bw), .i_kick(kick), .i_fail_req(fail),
      .o_done(done), .o_fail(ofail), .o_buf_busy(bbusy));
   task end_sim;
      if (n_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         end_sim;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task wrc(input logic [21:0] ad, input logic [15:0] dt);
      wr = 1'b1;
      wa = ad;
      wd = dt;
      @(posedge clk);
      #1;
   endtask
   task idle;
      wr = 1'b0;
      @(posedge clk);
      #1;
   endtask
   function automatic logic [15:0] exp_rd(input logic [1:0] sel);
      case (sel)
         2'h0: return arr;
         2'h1: return idd;
         2'h2: return 16'h0080;
         default: return 16'hFFFF;
      endcase
   endfunction
   task rdc(input logic [21:0] ad, input logic [1:0] sel);
      rd = 1'b1;
      ra = ad;
      arr = 16'($urandom);
      idd = 16'($urandom);
      @(posedge clk);
      #1;
      chk(rv, 1'h1);
      chk(rdat, exp_rd(sel));
      rd = 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic wait_done;
      int k = 0;
      while (done !== 1'b1 && k < 100)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k == 100) n_errors++;
      @(posedge clk);
      #1;
   endtask
   // Parameter blocks are 16 Kword, main blocks 64 Kword
   function automatic logic [21:0] blk_base(input logic [21:0] ad, input logic tp);
      if ((tp && ad[21:16] == 6'h3F) || (!tp && ad[21:16] == 6'h00))
         return {ad[21:14], 14'h0000};
      return {ad[21:16], 16'h0000};
   endfunction
   task automatic erase(input logic [21:0] ad, input logic [21:0] ad2);
      wrc(ad, 16'h0020);
      wrc(ad2, 16'h00D0);
      chk(st, 1'h1);
      chk(kind, 3'h1);
      chk(oa, blk_base(ad, top));
      idle;
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      void'($urandom(32'he6e0));
      chk(stat, 8'h80);
      a = {6'h01 + 6'($urandom % 61), 16'($urandom)};
      b = a + 22'h010000;
      fail = 1'b1;
      erase(a, b);
      chk(stat[7], 1'h0);
      wrc(a, 16'h00FF);
      idle;
      rdc(a, 2'h3);
      wrc(a ^ 22'h200000, 16'h00FF);
      idle;
      rdc(a ^ 22'h200000, 2'h0);
      wait_done;
      chk(stat, 8'hA0);
      fail = 1'b0;
      erase(b, b);
      wrc(b, 16'h0050);
      idle;
      wait_done;
      chk(stat, 8'hA0);
      wrc(b, 16'h0050);
      idle;
      chk(stat, 8'h80);
      for (int i = 0; i < 4; i++)
      begin
         top = i[0];
         a = {(i < 2) ? 6'h3F : 6'h00, 16'($urandom)};
         erase(a, a);
         wait_done;
      end
      a = 22'($urandom);
      d = 16'($urandom);
      wrc(a, 16'h0040);
      wrc(a, d);
      chk(kind, 3'h0);
      chk(od, d);
      idle;
      wrc(a, 16'h00B0);
      chk(sus, 1'h1);
      idle;
      wait_done;
      chk(stat, 8'h84);
      wrc(a, 16'h0020);
      wrc(a, 16'h00D0);
      chk(st | res, 1'h0);
      idle;
      wrc(a, 16'h00D0);
      chk(res, 1'h1);
      idle;
      wait_done;
      chk(stat, 8'h80);
      for (int i = 0; i < 4; i++)
      begin
         wrc(a, 16'h0060);
         wrc(a, lk[i]);
         chk(st, 1'h1);
         chk(kind, 3'h4 + 3'(i));
         idle;
         chk(stat[7], 1'h1);
      end
      wrc(22'h080000, 16'h0070);
      wrc(22'h100000, 16'h0090);
      wrc(22'h180000, 16'h00FF);
      idle;
      rdc(22'h080123, 2'h2);
      rdc(22'h100456, 2'h1);
      rdc(22'h180789, 2'h0);
      erase(22'h110000, 22'h110000);
      wait_done;
      rdc(22'h080123, 2'h2);
      a = {6'h22, 16'($urandom)};
      wrc(a, 16'h0030);
      chk(kind, 3'h3);
      chk(oa, {6'h22, 16'h0000});
      idle;
      d = 16'($urandom);
      wrc(a, d);
      chk(bw, 1'h1);
      chk(od, d);
      idle;
      wrc(a, ~d);
      chk(bw, 1'h0);
      idle;
      repeat (3) @(posedge clk);
      #1;
      wrc(a, d);
      chk(bw, 1'h1);
      idle;
      wrc(22'h000000, 16'hFFFF);
      idle;
      kick = 1'b1;
      @(posedge clk);
      #1;
      kick = 1'b0;
      wait_done;
      chk(stat, 8'h80);
      end_sim;
   end
endmodule
`default_nettype wire
